// [common/angx_consts.svh]
// register indices, field positions, reset values and masks of the negotiation register group
`ifndef ANGX_CONSTS_SVH
`define ANGX_CONSTS_SVH

// register indices on the management port
`define ANGX_IDX_EXP        5'h06
`define ANGX_IDX_NPTX       5'h07
`define ANGX_IDX_NPRX       5'h08
`define ANGX_IDX_MSCTL      5'h09

// expansion status field positions
`define ANGX_EXP_LOC_ABLE   6
`define ANGX_EXP_LOC        5
`define ANGX_EXP_PD_FAULT   4
`define ANGX_EXP_LP_NP      3
`define ANGX_EXP_NP_ABLE    2
`define ANGX_EXP_PAGE_RX    1
`define ANGX_EXP_LP_AN      0

// next-page field positions
`define ANGX_NP_TOGGLE      11

// role control field positions
`define ANGX_MS_TM_HI       15
`define ANGX_MS_TM_LO       13
`define ANGX_MS_FORCE       12
`define ANGX_MS_VALUE       11
`define ANGX_MS_PORT        10
`define ANGX_MS_ADV_FD      9
`define ANGX_MS_ADV_HD      8

// reset values
`define ANGX_NPTX_RST       16'h2001
`define ANGX_NPRX_RST       16'h0000
`define ANGX_MSCTL_RST      16'h0200
`define ANGX_LINKCFG_RST    24'h022001

// writable bits; all others are read-only
`define ANGX_NPTX_WMASK     16'hB7FF
`define ANGX_MSCTL_WMASK    16'hFF00

// widths of the words crossing to and from the link domain
`define ANGX_PAGE_W         16
`define ANGX_LINKCFG_W      24

`endif

// [common/angx_pkg.sv]
// types shared by the negotiation register group
package angx_pkg;

   // transmitter test mode selection
   typedef enum logic [2:0] {
      ANGX_TM_NORMAL   = 3'h0,
      ANGX_TM_WAVEFORM = 3'h1,
      ANGX_TM_JIT_MST  = 3'h2,
      ANGX_TM_JIT_SLV  = 3'h3,
      ANGX_TM_DISTORT  = 3'h4
   } angx_tmode_e;

   // settings sent to the link side
   typedef struct packed {
      logic [2:0] test_mode;   // effective test mode
      logic       ms_force;    // manual role enable
      logic       ms_master;   // forced role, master when high
      logic       port_multi;  // multi-port device
      logic       adv_fd;      // advertise gigabit full duplex
      logic       adv_hd;      // advertise gigabit half duplex
   } angx_linkcfg_s;

endpackage : angx_pkg

// [common/angx_xing_if.sv]
// carrier for one word crossing between the register and link clock domains
`timescale 1ns/1ps
interface angx_xing_if #(parameter int W = 16);
   logic         src_load;   // source offers a word
   logic [W-1:0] src_data;   // word offered
   logic         src_busy;   // crossing in flight, offers ignored
   logic         dst_valid;  // one-cycle pulse, new word delivered
   logic [W-1:0] dst_data;   // last word delivered

   modport sync (input src_load, input src_data, output src_busy,
                 output dst_valid, output dst_data);
   modport src  (output src_load, output src_data, input src_busy);
   modport dst  (input dst_valid, input dst_data);
endinterface : angx_xing_if

// [rtl/angx_evt_sync.sv]
// toggle-based crossing of single-cycle events between clock domains
`timescale 1ns/1ps
module angx_evt_sync (
   input  wire logic src_clk,
   input  wire logic dst_clk,
   input  wire logic rst,
   input  wire logic src_pulse,
   output logic      dst_pulse
);
   logic src_tgl_reg;  // flips once per event
   logic s1_reg;       // first stage, read only by s2
   logic s2_reg;       // second stage
   logic s3_reg;       // previous second stage, for edge detection

   // source side: an event becomes a level change that cannot be missed
   always_ff @(posedge src_clk or posedge rst) begin
      if (rst) src_tgl_reg <= 1'h0;
      else if (src_pulse) src_tgl_reg <= ~src_tgl_reg;
   end

   // destination side: two flops, then edge detection on the settled copy
   always_ff @(posedge dst_clk or posedge rst) begin
      if (rst) begin
         s1_reg <= 1'h0;
         s2_reg <= 1'h0;
         s3_reg <= 1'h0;
      end else begin
         s1_reg <= src_tgl_reg;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   assign dst_pulse = s2_reg ^ s3_reg;
endmodule : angx_evt_sync

// [rtl/angx_regs.sv]
// negotiation expansion, next-page and gigabit role control register group
//
// Contract
// R1: expansion bit 6 reads constant one
// R2: bit 5 reads one; partner pages in index 8
// R3: bit 4 latches parallel detection fault high
// R4: bit 3 reports partner next page ability
// R5: bit 2 reads one, read-only, local ability
// R6: bit 1 latches new page reception high
// R7: bit 0 reports partner negotiation ability
// R8: transmit page bits 15,13,10:0 writable, reset
// R9: software sets comply bit 12 as appropriate
// R10: device keeps read-only toggle at bit 11
// R11: receive page register read-only, holds partner page
// R12: bits 15:13 select transmitter test mode
// R13: bit 12 forces role from bit 11
// R14: bit 10 declares single or multi port
// R15: bit 9 advertises gigabit full duplex, reset one
// R16: software writes zero to half duplex bit
// R17: latched bits clear on read unless present
// R18: reserved bits read zero, ignore writes
`timescale 1ns/1ps
`include "angx_consts.svh"
module angx_regs
   import angx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        link_clk,
   input  wire logic [4:0]  mgmt_addr,
   input  wire logic        mgmt_wr_en,
   input  wire logic        mgmt_rd_en,
   input  wire logic [15:0] mgmt_wdata,
   output logic      [15:0] mgmt_rdata,
   output logic             mgmt_rd_valid,
   input  wire logic        link_page_rx_stb,
   input  wire logic [15:0] link_page_rx_word,
   input  wire logic        link_page_tx_stb,
   input  wire logic        link_pd_fault,
   input  wire logic        link_lp_an_able,
   input  wire logic        link_lp_np_able,
   output logic      [15:0] link_tx_page,
   output logic      [2:0]  link_test_mode,
   output logic             link_ms_force,
   output logic             link_ms_master,
   output logic             link_port_multi,
   output logic             link_adv_1000fd,
   output logic             link_adv_1000hd
);

   // index match for a management access
   function automatic logic idx_hit(input logic [4:0] addr, input logic [4:0] idx);
      idx_hit = (addr == idx);
   endfunction : idx_hit

   // reserved test codes fall back to normal operation
   function automatic logic [2:0] tm_eff(input logic [2:0] code);
      tm_eff = (code > ANGX_TM_DISTORT) ? ANGX_TM_NORMAL : code;
   endfunction : tm_eff

   logic [15:0]   nptx_reg;        // transmit next page, toggle bit held apart
   logic          tx_tgl_reg;      // transmit toggle, device owned
   logic [15:0]   nprx_reg;        // last page received from the partner
   logic [15:0]   msctl_reg;       // role and test control
   logic          pd_lh_reg;       // latched parallel detection fault
   logic          page_lh_reg;     // latched page reception
   logic          pd_s1_reg;       // fault level, first stage
   logic          pd_s2_reg;       // fault level, settled
   logic          an_s1_reg;       // partner negotiation ability, first stage
   logic          an_s2_reg;       // partner negotiation ability, settled
   logic          np_s1_reg;       // partner next page ability, first stage
   logic          np_s2_reg;       // partner next page ability, settled
   logic [15:0]   rdata_next;      // read mux
   logic [15:0]   exp_word;        // expansion status image
   logic [15:0]   nptx_word;       // transmit page image with toggle
   logic          exp_read;        // expansion register read this cycle
   logic          tx_done_pulse;   // a page left the link, register domain
   logic          rx_new;          // a partner page arrived, register domain
   angx_linkcfg_s cfg;             // settings for the link side
   angx_linkcfg_s link_cfg;        // settings as seen by the link side

   angx_xing_if #(.W(`ANGX_PAGE_W))    rx_x ();  // partner pages inward
   angx_xing_if #(.W(`ANGX_LINKCFG_W)) cfg_x ();  // settings outward

   // level inputs from the link cross through two flops each
   // only the second stage feeds logic; the first may still be settling
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pd_s1_reg <= 1'h0;
         pd_s2_reg <= 1'h0;
         an_s1_reg <= 1'h0;
         an_s2_reg <= 1'h0;
         np_s1_reg <= 1'h0;
         np_s2_reg <= 1'h0;
      end else begin
         pd_s1_reg <= link_pd_fault;
         pd_s2_reg <= pd_s1_reg;
         an_s1_reg <= link_lp_an_able;
         an_s2_reg <= an_s1_reg;
         np_s1_reg <= link_lp_np_able;
         np_s2_reg <= np_s1_reg;
      end
   end

   // partner pages cross as a whole word so no page is seen half updated
   assign rx_x.src_load = link_page_rx_stb;
   assign rx_x.src_data = link_page_rx_word;
   angx_word_sync #(.W(`ANGX_PAGE_W), .RST_VAL(`ANGX_NPRX_RST)) u_rx_sync (
      .src_clk (link_clk),
      .dst_clk (clk),
      .rst     (rst),
      .x       (rx_x)
   );
   assign rx_new = rx_x.dst_valid;

   // transmitted-page events arrive as pulses
   angx_evt_sync u_tx_evt (
      .src_clk   (link_clk),
      .dst_clk   (clk),
      .rst       (rst),
      .src_pulse (link_page_tx_stb),
      .dst_pulse (tx_done_pulse)
   );

   assign exp_read = mgmt_rd_en && idx_hit(mgmt_addr, `ANGX_IDX_EXP);

   // parallel fault latch: set wins over the clearing read
   // trade-off: a fault still present at a read stays visible until the next read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) pd_lh_reg <= 1'h0;
      else if (pd_s2_reg) pd_lh_reg <= 1'h1;  // R3 R17
      else if (exp_read) pd_lh_reg <= 1'h0;   // R17
   end

   // page reception latch: an arrival in the read cycle is kept
   always_ff @(posedge clk or posedge rst) begin
      if (rst) page_lh_reg <= 1'h0;
      else if (rx_new) page_lh_reg <= 1'h1;     // R6
      else if (exp_read) page_lh_reg <= 1'h0;   // R17
   end

   // received page store, never written by software
   always_ff @(posedge clk or posedge rst) begin
      if (rst) nprx_reg <= `ANGX_NPRX_RST;
      else if (rx_new) nprx_reg <= rx_x.dst_data;  // R2 R11
   end

   // transmit page: only the writable bits take software data
   // the comply bit is software owned; the device never alters it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) nptx_reg <= `ANGX_NPTX_RST;  // R8
      else if (mgmt_wr_en && idx_hit(mgmt_addr, `ANGX_IDX_NPTX))
         nptx_reg <= mgmt_wdata & `ANGX_NPTX_WMASK;  // R8 R9 R18
   end

   // transmit toggle flips after each page sent, so the next page carries the opposite
   // strobes closer than the crossing allows would merge; the link keeps them apart
   always_ff @(posedge clk or posedge rst) begin
      if (rst) tx_tgl_reg <= 1'h0;
      else if (tx_done_pulse) tx_tgl_reg <= ~tx_tgl_reg;  // R10
   end

   // role and test control; half duplex bit is stored as written
   // reserved test codes are kept so software reads back its own value
   always_ff @(posedge clk or posedge rst) begin
      if (rst) msctl_reg <= `ANGX_MSCTL_RST;  // R15
      else if (mgmt_wr_en && idx_hit(mgmt_addr, `ANGX_IDX_MSCTL))
         msctl_reg <= mgmt_wdata & `ANGX_MSCTL_WMASK;  // R12 R14 R16 R18
   end

   // expansion image: constants for local abilities, reserved bits zero
   always_comb begin
      exp_word                     = 16'h0000;  // R18
      exp_word[`ANGX_EXP_LOC_ABLE] = 1'h1;  // R1
      exp_word[`ANGX_EXP_LOC]      = 1'h1;  // R2
      exp_word[`ANGX_EXP_PD_FAULT] = pd_lh_reg;  // R3
      exp_word[`ANGX_EXP_LP_NP]    = np_s2_reg;  // R4
      exp_word[`ANGX_EXP_NP_ABLE]  = 1'h1;  // R5
      exp_word[`ANGX_EXP_PAGE_RX]  = page_lh_reg;  // R6
      exp_word[`ANGX_EXP_LP_AN]    = an_s2_reg;  // R7
   end

   // transmit image carries the device toggle
   always_comb begin
      nptx_word                 = nptx_reg;
      nptx_word[`ANGX_NP_TOGGLE] = tx_tgl_reg;  // R10
   end

   // read mux; unmapped indices read zero
   always_comb begin
      case (mgmt_addr)
         `ANGX_IDX_EXP:   rdata_next = exp_word;
         `ANGX_IDX_NPTX:  rdata_next = nptx_word;
         `ANGX_IDX_NPRX:  rdata_next = nprx_reg;  // R11
         `ANGX_IDX_MSCTL: rdata_next = msctl_reg;
         default:         rdata_next = 16'h0000;
      endcase
   end

   // read data registered; taken at the same edge that clears the latches
   // read data holds between reads so slow software still sees it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mgmt_rdata    <= 16'h0000;
         mgmt_rd_valid <= 1'h0;
      end else begin
         mgmt_rd_valid <= mgmt_rd_en;
         if (mgmt_rd_en) mgmt_rdata <= rdata_next;
      end
   end

   // settings for the link; the role value only matters while forcing
   always_comb begin
      cfg.test_mode  = tm_eff(msctl_reg[`ANGX_MS_TM_HI:`ANGX_MS_TM_LO]);  // R12
      cfg.ms_force   = msctl_reg[`ANGX_MS_FORCE];  // R13
      cfg.ms_master  = msctl_reg[`ANGX_MS_FORCE] & msctl_reg[`ANGX_MS_VALUE];  // R13
      cfg.port_multi = msctl_reg[`ANGX_MS_PORT];  // R14
      cfg.adv_fd     = msctl_reg[`ANGX_MS_ADV_FD];  // R15
      cfg.adv_hd     = msctl_reg[`ANGX_MS_ADV_HD];
   end

   // limitation: a write reaches the link some cycles later, never at once
   // settings are resent whenever the crossing is idle; a change reaches the
   // link within a few link cycles without a per-field handshake
   assign cfg_x.src_load = 1'h1;
   assign cfg_x.src_data = {cfg, nptx_word};
   angx_word_sync #(.W(`ANGX_LINKCFG_W), .RST_VAL(`ANGX_LINKCFG_RST)) u_cfg_sync (
      .src_clk (clk),
      .dst_clk (link_clk),
      .rst     (rst),
      .x       (cfg_x)
   );

   // link-domain outputs straight from the delivered word register
   assign link_cfg        = cfg_x.dst_data[`ANGX_LINKCFG_W-1:`ANGX_PAGE_W];
   assign link_tx_page    = cfg_x.dst_data[`ANGX_PAGE_W-1:0];
   assign link_test_mode  = link_cfg.test_mode;
   assign link_ms_force   = link_cfg.ms_force;
   assign link_ms_master  = link_cfg.ms_master;
   assign link_port_multi = link_cfg.port_multi;
   assign link_adv_1000fd = link_cfg.adv_fd;
   assign link_adv_1000hd = link_cfg.adv_hd;

   // checks in the register domain
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_exp_const_bits: assert property (  // R1
      exp_read |=> mgmt_rdata[15:7] == 9'h000 && mgmt_rdata[`ANGX_EXP_LOC_ABLE])
      else $error("expansion constant or reserved bits wrong");

   a_exp_loc_bits: assert property (  // R2
      exp_read |=> mgmt_rdata[`ANGX_EXP_LOC] && mgmt_rdata[`ANGX_EXP_NP_ABLE])
      else $error("storage location or local ability bit not one");

   a_pd_fault_set: assert property (  // R3
      pd_s2_reg |=> pd_lh_reg)
      else $error("parallel fault not latched");

   a_lp_np_report: assert property (  // R4
      exp_read |=> mgmt_rdata[`ANGX_EXP_LP_NP] == $past(np_s2_reg))
      else $error("partner next page ability misreported");

   a_np_able_const: assert property (  // R5
      exp_read |=> mgmt_rd_valid && mgmt_rdata[`ANGX_EXP_NP_ABLE])
      else $error("local next page ability not one");

   a_page_rx_set: assert property (  // R6
      rx_new |=> page_lh_reg ##0 nprx_reg == $past(rx_x.dst_data))
      else $error("page reception not latched with its page");

   a_lp_an_report: assert property (  // R7
      exp_read |=> mgmt_rdata[`ANGX_EXP_LP_AN] == $past(an_s2_reg))
      else $error("partner negotiation ability misreported");

   a_nptx_write: assert property (  // R8
      mgmt_wr_en && idx_hit(mgmt_addr, `ANGX_IDX_NPTX)
      |=> nptx_reg == ($past(mgmt_wdata) & `ANGX_NPTX_WMASK))
      else $error("transmit page write not stored");

   a_toggle_ro: assert property (  // R10
      !tx_done_pulse |=> $stable(tx_tgl_reg))
      else $error("toggle changed without a transmitted page");

   a_rx_page_ro: assert property (  // R11
      !rx_new |=> $stable(nprx_reg))
      else $error("received page changed without a partner page");

   a_test_mode_sel: assert property (  // R12
      msctl_reg[15:13] > 3'h4 |-> cfg.test_mode == 3'h0)
      else $error("reserved test code reaches the link");

   a_role_force: assert property (  // R13
      !msctl_reg[`ANGX_MS_FORCE] |-> !cfg.ms_master && !cfg.ms_force)
      else $error("role forced while manual enable is off");

   a_msctl_write: assert property (  // R14
      mgmt_wr_en && idx_hit(mgmt_addr, `ANGX_IDX_MSCTL)
      |=> msctl_reg[`ANGX_MS_PORT] == $past(mgmt_wdata[`ANGX_MS_PORT])
          && msctl_reg[7:0] == 8'h00)
      else $error("role control write not stored");

   a_lh_clear_read: assert property (  // R17
      exp_read && !pd_s2_reg && !rx_new |=> !pd_lh_reg && !page_lh_reg)
      else $error("latched bits not cleared by read");

   a_lh_hold: assert property (  // R17
      page_lh_reg && !exp_read |=> page_lh_reg)
      else $error("page latch dropped without a read");

   // toggle and received page as software sees them
   a_toggle_flip: assert property (  // R10
      tx_done_pulse |=> tx_tgl_reg != $past(tx_tgl_reg))
      else $error("toggle did not flip after a transmitted page");

   a_nprx_read: assert property (  // R11
      mgmt_rd_en && idx_hit(mgmt_addr, `ANGX_IDX_NPRX) |=> mgmt_rdata == $past(nprx_reg))
      else $error("received page readback wrong");

   // link-side settings follow the control register
   a_test_mode_pass: assert property (  // R12
      msctl_reg[`ANGX_MS_TM_HI:`ANGX_MS_TM_LO] <= 3'h4
      |-> cfg.test_mode == msctl_reg[`ANGX_MS_TM_HI:`ANGX_MS_TM_LO])
      else $error("defined test code not passed to the link");

   a_role_value: assert property (  // R13
      cfg.ms_force |-> cfg.ms_master == msctl_reg[`ANGX_MS_VALUE])
      else $error("forced role differs from the role value bit");

   a_port_type: assert property (  // R14
      cfg.port_multi == msctl_reg[`ANGX_MS_PORT])
      else $error("port type not passed to the link");

   a_adv_fd_map: assert property (  // R15
      cfg.adv_fd == msctl_reg[`ANGX_MS_ADV_FD])
      else $error("full duplex advertisement not passed to the link");

   c_page_then_read: cover property (rx_new ##[1:20] exp_read);
   c_fault_read: cover property (pd_lh_reg && exp_read);
   c_set_clear_same: cover property (rx_new && exp_read);
   c_tx_toggle: cover property (tx_done_pulse ##[1:50] tx_done_pulse);
   c_forced_master: cover property (cfg.ms_force && cfg.ms_master);

endmodule : angx_regs

// [rtl/angx_word_sync.sv]
// two-phase handshake crossing of a whole word; the held word is stable while in flight
`timescale 1ns/1ps
module angx_word_sync #(
   parameter int           W       = 16,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic src_clk,
   input  wire logic dst_clk,
   input  wire logic rst,
   angx_xing_if.sync x
);
   logic [W-1:0] hold_reg;     // word frozen until acknowledged
   logic         req_reg;      // request toggle, source domain
   logic         ack_s1_reg;   // ack first stage
   logic         ack_s2_reg;   // ack second stage
   logic         req_s1_reg;   // request first stage
   logic         req_s2_reg;   // request second stage
   logic         seen_reg;     // last request taken, doubles as ack
   logic         valid_reg;    // delivery pulse
   logic [W-1:0] data_reg;     // delivered word

   // busy while the acknowledge has not come back
   assign x.src_busy = req_reg ^ ack_s2_reg;

   // source: capture and raise the request only when idle
   always_ff @(posedge src_clk or posedge rst) begin
      if (rst) begin
         hold_reg <= RST_VAL;
         req_reg  <= 1'h0;
      end else if (x.src_load && !x.src_busy) begin
         hold_reg <= x.src_data;
         req_reg  <= ~req_reg;
      end
   end

   // source: acknowledge back through two flops
   always_ff @(posedge src_clk or posedge rst) begin
      if (rst) begin
         ack_s1_reg <= 1'h0;
         ack_s2_reg <= 1'h0;
      end else begin
         ack_s1_reg <= seen_reg;
         ack_s2_reg <= ack_s1_reg;
      end
   end

   // destination: take the held word once the request has settled
   always_ff @(posedge dst_clk or posedge rst) begin
      if (rst) begin
         req_s1_reg <= 1'h0;
         req_s2_reg <= 1'h0;
         seen_reg   <= 1'h0;
         valid_reg  <= 1'h0;
         data_reg   <= RST_VAL;
      end else begin
         req_s1_reg <= req_reg;
         req_s2_reg <= req_s1_reg;
         valid_reg  <= req_s2_reg ^ seen_reg;
         if (req_s2_reg ^ seen_reg) begin
            seen_reg <= req_s2_reg;
            data_reg <= hold_reg;
         end
      end
   end

   assign x.dst_valid = valid_reg;
   assign x.dst_data  = data_reg;
endmodule : angx_word_sync

// [test/angx_link_model.sv]
// far-side link logic model: partner page and transmitted-page strobes
`timescale 1ns/1ps
module angx_link_model (
   input  wire logic        link_clk,
   output logic             page_rx_stb,
   output logic      [15:0] page_rx_word,
   output logic             page_tx_stb
);
   // idle outputs; the page word never rests on a value that could pass by chance
   initial begin
      page_rx_stb  = 1'b0;
      page_tx_stb  = 1'b0;
      page_rx_word = 16'hA5C3;
   end

   // one received page: strobe for one link cycle, then the word is inverted
   // so a design that samples outside the strobe picks up garbage
   task automatic send_page(input logic [15:0] w);
      @(posedge link_clk);
      #1;
      page_rx_stb  = 1'b1;
      page_rx_word = w;
      @(posedge link_clk);
      #1;
      page_rx_stb  = 1'b0;
      page_rx_word = ~w;
      repeat (10) @(posedge link_clk);
   endtask : send_page

   // one transmitted page; pulses kept at least two link cycles apart
   task automatic send_tx;
      @(posedge link_clk);
      #1;
      page_tx_stb = 1'b1;
      @(posedge link_clk);
      #1;
      page_tx_stb = 1'b0;
      repeat (2) @(posedge link_clk);
   endtask : send_tx
endmodule : angx_link_model

// [test/tb.sv]
// testbench of the negotiation register group with a far-side link model
`timescale 1ns/1ps
`include "angx_consts.svh"
module tb;
   import angx_pkg::*;
   logic        clk;              // register clock
   logic        link_clk;         // link clock, own phase
   logic        rst;              // async reset
   logic [4:0]  mgmt_addr;        // register index
   logic        mgmt_wr_en;       // write strobe
   logic        mgmt_rd_en;       // read strobe
   logic [15:0] mgmt_wdata;       // write data
   logic [15:0] mgmt_rdata;       // read data
   logic        mgmt_rd_valid;    // read answer
   logic        rx_stb;           // partner page strobe
   logic [15:0] rx_word;          // partner page word
   logic        tx_stb;           // transmitted page strobe
   logic        pd_fault;         // parallel detection fault level
   logic        lp_an;            // partner negotiation able level
   logic        lp_np;            // partner next page able level
   logic [15:0] tx_page;          // transmit page at the link
   logic [2:0]  tmode;            // effective test mode
   logic        ms_force;         // manual role enable
   logic        ms_master;        // forced master
   logic        port_multi;       // multi-port
   logic        adv_fd;           // full duplex advert
   logic        adv_hd;           // half duplex advert
   logic [15:0] v;                // role control word under test
   int          errors;
   int          n_tests;

   angx_regs i_dut (.clk(clk), .rst(rst), .link_clk(link_clk), .mgmt_addr(mgmt_addr),
      .mgmt_wr_en(mgmt_wr_en), .mgmt_rd_en(mgmt_rd_en), .mgmt_wdata(mgmt_wdata),
      .mgmt_rdata(mgmt_rdata), .mgmt_rd_valid(mgmt_rd_valid), .link_page_rx_stb(rx_stb),
      .link_page_rx_word(rx_word), .link_page_tx_stb(tx_stb), .link_pd_fault(pd_fault),
      .link_lp_an_able(lp_an), .link_lp_np_able(lp_np), .link_tx_page(tx_page),
      .link_test_mode(tmode), .link_ms_force(ms_force), .link_ms_master(ms_master),
      .link_port_multi(port_multi), .link_adv_1000fd(adv_fd), .link_adv_1000hd(adv_hd));

   angx_link_model i_link (.link_clk(link_clk), .page_rx_stb(rx_stb),
      .page_rx_word(rx_word), .page_tx_stb(tx_stb));

   // register clock
   always #2.5 clk = ~clk;

   // link clock, offset so the two domains never line up
   initial begin
      link_clk = 1'b0;
      #7.3;
      forever #15 link_clk = ~link_clk;
   end

   // compare and count; x never matches
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // one write cycle on the management port
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      mgmt_addr  = a;
      mgmt_wdata = d;
      mgmt_wr_en = 1'b1;
      @(posedge clk);
      #1;
      mgmt_wr_en = 1'b0;
   endtask : wr

   // one read; the answer stands for exactly the cycle after the strobe
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk);
      #1;
      mgmt_addr  = a;
      mgmt_rd_en = 1'b1;
      @(posedge clk);
      #1;
      mgmt_rd_en = 1'b0;
      chk("rd_valid", {15'h0, mgmt_rd_valid}, 16'h0001);
      chk("rdata", mgmt_rdata, e);
   endtask : rd

   // verdict and end of run
   task automatic test_done;
      if (errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   // hang guard
   initial begin
      #500000;
      errors++;
      test_done();
   end

   // main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      mgmt_addr = 5'h00;
      mgmt_wr_en = 1'b0;
      mgmt_rd_en = 1'b0;
      mgmt_wdata = 16'h0000;
      pd_fault = 1'b0;
      lp_an = 1'b0;
      lp_np = 1'b0;
      errors = 0;
      n_tests = 0;
      // link side needs three of its own edges under reset
      repeat (3) @(posedge link_clk);
      @(posedge clk);
      #1;
      rst = 1'b0;
      chk("tx_page", tx_page, `ANGX_NPTX_RST);
      chk("adv", {14'h0, adv_fd, adv_hd}, 16'h0002);
      rd(`ANGX_IDX_EXP, 16'h0064);
      rd(`ANGX_IDX_NPTX, `ANGX_NPTX_RST);
      rd(`ANGX_IDX_NPRX, 16'h0000);
      rd(`ANGX_IDX_MSCTL, `ANGX_MSCTL_RST);
      // read-only and reserved bits hold against all-ones writes
      wr(`ANGX_IDX_NPTX, 16'hFFFF);
      rd(`ANGX_IDX_NPTX, 16'hB7FF);
      wr(`ANGX_IDX_EXP, 16'hFFFF);
      rd(`ANGX_IDX_EXP, 16'h0064);
      wr(`ANGX_IDX_NPRX, 16'hFFFF);
      rd(`ANGX_IDX_NPRX, 16'h0000);
      wr(5'h1F, 16'hFFFF);
      rd(5'h1F, 16'h0000);
      // toggle flips on each transmitted page in readback; the first flip is also checked at the link
      i_link.send_tx();
      rd(`ANGX_IDX_NPTX, 16'hBFFF);
      repeat (80) @(posedge clk);
      chk("tx_page", tx_page, 16'hBFFF);
      i_link.send_tx();
      rd(`ANGX_IDX_NPTX, 16'hB7FF);
      // every test code, role forcing and port type
      for (int c = 0; c < 8; c++) begin
         v = {c[2:0], c[0], c[1], c[2], 1'b1, 1'b0, 8'h00};
         wr(`ANGX_IDX_MSCTL, v);
         rd(`ANGX_IDX_MSCTL, v);
         repeat (80) @(posedge clk);
         chk("test_mode", {13'h0, tmode}, (c < 5) ? 16'(c) : 16'h0000);
         chk("role", {13'h0, ms_force, ms_master, port_multi},
             {13'h0, c[0], c[0] & c[1], c[2]});
         chk("adv", {14'h0, adv_fd, adv_hd}, 16'h0002);
      end
      // partner page lands in index 8, arrival latched until read
      i_link.send_page(16'h5A5A);
      rd(`ANGX_IDX_EXP, 16'h0066);
      rd(`ANGX_IDX_EXP, 16'h0064);
      rd(`ANGX_IDX_NPRX, 16'h5A5A);
      // fault latches, survives a read while present, clears after it passes
      pd_fault = 1'b1;
      repeat (6) @(posedge clk);
      rd(`ANGX_IDX_EXP, 16'h0074);
      rd(`ANGX_IDX_EXP, 16'h0074);
      pd_fault = 1'b0;
      repeat (6) @(posedge clk);
      rd(`ANGX_IDX_EXP, 16'h0074);
      rd(`ANGX_IDX_EXP, 16'h0064);
      // partner abilities are live levels
      lp_np = 1'b1;
      lp_an = 1'b1;
      repeat (6) @(posedge clk);
      rd(`ANGX_IDX_EXP, 16'h006D);
      lp_np = 1'b0;
      lp_an = 1'b0;
      repeat (6) @(posedge clk);
      rd(`ANGX_IDX_EXP, 16'h0064);
      test_done();
   end
endmodule : tb
